// ===== rtl/rfsc_sleep_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module rfsc_sleep_ctrl
	import rfsc_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC,
	parameter int HIB_CYCLES  = HIB_WAKE_CYC,
	parameter int DOZE_CYCLES = DOZE_WAKE_CYC
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// axi4-lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// host pins
	input  wire logic        sleepRequest,
	output logic             ctsN,
	// modem core hooks
	input  wire logic        hostActivity,
	input  wire logic        radioActivity,
	input  wire logic        coreBusy,
	input  wire logic        pollReceived,
	input  wire logic [63:0] pollSource,
	input  wire logic        queuedDataRx,
	output logic             sleeping,
	output logic             pollReq,
	output logic             msgSend,
	output logic [63:0]      msgDest,
	output logic             msgDropped
);
	// ---------------------------------------------------------------
	// pin synchroniser
	// ---------------------------------------------------------------
	logic reqMeta_r, reqSync_r, reqPrev_r;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reqMeta_r <= 1'b0;
			reqSync_r <= 1'b0;
			reqPrev_r <= 1'b0;
		end else begin
			reqMeta_r <= sleepRequest;
			reqSync_r <= reqMeta_r;
			reqPrev_r <= reqSync_r;
		end
	end
	wire reqFall = reqPrev_r & ~reqSync_r;

	// ---------------------------------------------------------------
	// configuration registers
	// ---------------------------------------------------------------
	logic [2:0]  sleepModeSelect_r;  // mode field
	logic        coordEnable_r;      // coordinator enable
	logic [15:0] cyclicSleepPeriod_r;       // in ms ticks
	logic [15:0] idleBeforeSleepTimer_r;    // in ms ticks
	logic [63:0] queueAddr_r;        // staged message destination
	rfsc_mode_e  mode;

	// unlisted codes fall back to disabled
	always_comb begin
		case (sleepModeSelect_r)
			3'h1, 3'h2, 3'h4, 3'h5, 3'h6: mode = rfsc_mode_e'(sleepModeSelect_r);
			default: mode = SM_OFF;
		endcase
	end
	wire pinMode  = (mode == SM_HIB) || (mode == SM_DOZE);
	wire cycMode  = (mode == SM_CYC) || (mode == SM_CYCPIN);
	wire isCoord  = ((mode == SM_OFF) && coordEnable_r) || (mode == SM_LEGCO);

	// ---------------------------------------------------------------
	// axi4-lite slave: one write and one read at a time
	// ---------------------------------------------------------------
	logic awHeld_r, wHeld_r;
	logic [7:0]  awAddr_r;
	logic [31:0] wData_r;
	logic        queuePulse_r;
	assign s_axi_awready = ~awHeld_r & ~s_axi_bvalid;
	assign s_axi_wready  = ~wHeld_r & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;
	wire doWrite = awHeld_r & wHeld_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			awHeld_r <= 1'b0;
			wHeld_r <= 1'b0;
			awAddr_r <= 8'h00;
			wData_r <= 32'h0000_0000;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_r <= 1'b1;
				awAddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_r <= 1'b1;
				wData_r <= s_axi_wdata;
			end
			if (doWrite) begin
				awHeld_r <= 1'b0;
				wHeld_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awAddr_r <= ADDR_MSGADDR && awAddr_r[1:0] == 2'h0
					&& awAddr_r != ADDR_STATUS) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// register writes; strobes ignored for simplicity, full word writes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sleepModeSelect_r <= MODE_RST;
			coordEnable_r <= 1'b0;
			cyclicSleepPeriod_r <= PERIOD_RST;
			idleBeforeSleepTimer_r <= IDLE_RST;
			queueAddr_r <= 64'h0;
			queuePulse_r <= 1'b0;
		end else begin
			queuePulse_r <= 1'b0;
			if (doWrite) begin
				case (awAddr_r)
					ADDR_CTRL: begin
						sleepModeSelect_r <= wData_r[CTRL_MODE_LSB +: 3];
						coordEnable_r <= wData_r[CTRL_COORD_BIT];
					end
					ADDR_PERIOD:  cyclicSleepPeriod_r <= wData_r[15:0];
					ADDR_IDLE:    idleBeforeSleepTimer_r <= wData_r[15:0];
					ADDR_MSGADDR: begin
						queueAddr_r <= {32'h0, wData_r};
						queuePulse_r <= 1'b1;
					end
					default: ;
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// tick divider: one enable pulse per millisecond
	// ---------------------------------------------------------------
	logic [31:0] tickCnt_r;
	wire tick = (tickCnt_r == 32'(TICK_CYCLES - 1));
	always_ff @(posedge clk or posedge rst) begin
		if (rst) tickCnt_r <= 32'h0;
		else tickCnt_r <= tick ? 32'h0 : tickCnt_r + 32'h1;
	end

	// ---------------------------------------------------------------
	// sleep state machine
	// ---------------------------------------------------------------
	rfsc_state_e state_r;
	logic [31:0] cnt_r;      // wake delay in cycles or period in ticks
	logic [15:0] idleCnt_r;  // idle timer in ticks
	logic        pinWoken_r; // woken by pin in mode five
	logic        pollPend_r;
	wire activity = hostActivity | radioActivity;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= ST_AWAKE;
			cnt_r <= 32'h0;
			idleCnt_r <= 16'h0;
			pinWoken_r <= 1'b0;
			pollPend_r <= 1'b0;
			pollReq <= 1'b0;
		end else begin
			pollReq <= 1'b0;
			case (state_r)
				ST_AWAKE: begin
					if (activity) idleCnt_r <= 16'h0;
					else if (tick && idleCnt_r != 16'hFFFF) idleCnt_r <= idleCnt_r + 16'h1;
					if (pinMode && reqSync_r) begin
						state_r <= ST_DRAIN;
					end else if (cycMode && !activity && idleCnt_r >= idleBeforeSleepTimer_r) begin
						state_r <= ST_SLEEP;
						cnt_r <= 32'h0;
						pinWoken_r <= 1'b0;
					end
				end
				ST_DRAIN: begin
					// finish ongoing work, pass idle, then sleep
					if (!pinMode || !reqSync_r) state_r <= ST_AWAKE;
					else if (!coreBusy) state_r <= ST_SLEEP;
				end
				ST_SLEEP: begin
					// host and radio activity ignored here
					if (pinMode && !reqSync_r) begin
						state_r <= ST_WAKING;
						cnt_r <= (mode == SM_HIB) ? 32'(HIB_CYCLES) : 32'(DOZE_CYCLES);
					end else if (mode == SM_CYCPIN && reqFall) begin
						state_r <= ST_WAKING;
						pinWoken_r <= 1'b1;
						cnt_r <= 32'(DOZE_CYCLES);
					end else if (cycMode) begin
						if (tick) cnt_r <= cnt_r + 32'h1;
						if (cnt_r >= {16'h0, cyclicSleepPeriod_r}) begin
							state_r <= ST_WAKING;
							pollPend_r <= 1'b1;
							cnt_r <= 32'(DOZE_CYCLES);
						end
					end else if (!pinMode) begin
						state_r <= ST_AWAKE;
					end
				end
				ST_WAKING: begin
					if (cnt_r != 32'h0) cnt_r <= cnt_r - 32'h1;
					else if (pollPend_r) begin
						state_r <= ST_POLL;
						pollReq <= 1'b1;
						pollPend_r <= 1'b0;
						cnt_r <= 32'h0;
					end else begin
						state_r <= ST_AWAKE;
						idleCnt_r <= 16'h0;
					end
				end
				ST_POLL: begin
					// wait one idle-timer-length window for queued data
					if (tick) cnt_r <= cnt_r + 32'h1;
					if (queuedDataRx) begin
						state_r <= ST_AWAKE;
						idleCnt_r <= 16'h0;
					end else if (hostActivity || (mode == SM_CYCPIN && reqFall)) begin
						state_r <= ST_AWAKE;
						idleCnt_r <= 16'h0;
					end else if (cnt_r >= {16'h0, idleBeforeSleepTimer_r}) begin
						state_r <= ST_SLEEP;
						cnt_r <= 32'h0;
					end
				end
				default: state_r <= ST_AWAKE;
			endcase
		end
	end

	// clear-to-send low only while awake and ready
	assign ctsN = ~(state_r == ST_AWAKE || state_r == ST_POLL);
	assign sleeping = (state_r == ST_SLEEP);

	// ---------------------------------------------------------------
	// coordinator: single indirect message slot
	// ---------------------------------------------------------------
	rfsc_msg_s msg_r;
	wire [31:0] retainHalves = 32'(RETAIN_HALVES) * {16'h0, cyclicSleepPeriod_r};
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			msg_r <= '0;
			msgSend <= 1'b0;
			msgDest <= 64'h0;
			msgDropped <= 1'b0;
		end else begin
			msgSend <= 1'b0;
			msgDropped <= 1'b0;
			if (!isCoord) begin
				msg_r.valid <= 1'b0;
			end else if (msg_r.valid && pollReceived && pollSource == msg_r.dest) begin
				msg_r.valid <= 1'b0;
				msgSend <= 1'b1;
				msgDest <= msg_r.dest;
			end else if (msg_r.valid && msg_r.age >= retainHalves) begin
				msg_r.valid <= 1'b0;
				msgDropped <= 1'b1;
			end else if (queuePulse_r && !msg_r.valid) begin
				msg_r.valid <= 1'b1;
				msg_r.dest <= queueAddr_r;
				msg_r.age <= 32'h0;
			end else if (msg_r.valid && tick) begin
				// age counted in half-ms so 2.5 periods stays exact
				msg_r.age <= msg_r.age + 32'h2;
			end
		end
	end

	// ---------------------------------------------------------------
	// read path
	// ---------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			case (s_axi_araddr)
				ADDR_CTRL:    s_axi_rdata <= {28'h0, coordEnable_r, sleepModeSelect_r};
				ADDR_PERIOD:  s_axi_rdata <= {16'h0, cyclicSleepPeriod_r};
				ADDR_IDLE:    s_axi_rdata <= {16'h0, idleBeforeSleepTimer_r};
				ADDR_STATUS:  s_axi_rdata <= {26'h0, msg_r.valid, isCoord, pinWoken_r, state_r};
				ADDR_MSGADDR: s_axi_rdata <= queueAddr_r[31:0];
				default: begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ===== rtl/rfsc_pkg.sv
// Operation
// - hibernate: level request, finish work, idle, sleep
// - pin sleep ignores serial and radio activity
// - release request wakes; clear-to-send low
// - hibernate wake time about ten ms
// - doze like hibernate, shorter wake time
// - cyclic remote wakes each period, sends poll
// - coordinator sends queued data on poll
// - empty poll: sleep another full period
// - data after poll: stay awake until timer
// - cyclic remote drives clear-to-send low on wake
// - mode five also wakes on request falling edge
// - activity restarts idle timer fully
// - pin-woken module ignores pin, timer decides
// - mode zero plus coordinator enable: coordinator
// - coordinator holds one indirect message per remote (code keeps a single slot for all remotes)
// - undelivered message dropped after 2.5 periods
// - legacy coordinator mode stays always awake
// - mode zero never sleeps, stays idle/receive
// - idle timer only in modes four and five
package rfsc_pkg;
	// ---------------------------------------------------------------
	// register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_PERIOD  = 8'h04;
	localparam logic [7:0] ADDR_IDLE    = 8'h08;
	localparam logic [7:0] ADDR_EVENT   = 8'h0C;
	localparam logic [7:0] ADDR_STATUS  = 8'h10;
	localparam logic [7:0] ADDR_MSGADDR = 8'h14;
	// ---------------------------------------------------------------
	// field positions and reset values
	// ---------------------------------------------------------------
	localparam int CTRL_MODE_LSB   = 0;
	localparam int CTRL_COORD_BIT  = 3;
	localparam int EVT_ACT_BIT     = 0;
	localparam int EVT_BUSY_BIT    = 1;
	localparam int EVT_POLLQ_BIT   = 2;
	localparam int EVT_DATA_BIT    = 3;
	localparam int EVT_QUEUE_BIT   = 4;
	localparam int EVT_DELIV_BIT   = 5;
	localparam logic [2:0]  MODE_RST   = 3'h0;
	localparam logic [15:0] PERIOD_RST = 16'h0064;
	localparam logic [15:0] IDLE_RST   = 16'h0032;
	localparam logic [1:0]  RESP_OKAY  = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	// ---------------------------------------------------------------
	// timing: one tick per 1 ms; wake delays in us
	// ---------------------------------------------------------------
	localparam int CLK_MHZ        = 125;
	localparam int TICK_US        = 1000;
	localparam int HIB_WAKE_US    = 10200;
	localparam int DOZE_WAKE_US   = 2600;
	localparam int TICK_CYC       = TICK_US * CLK_MHZ;
	localparam int HIB_WAKE_CYC   = HIB_WAKE_US * CLK_MHZ;
	localparam int DOZE_WAKE_CYC  = DOZE_WAKE_US * CLK_MHZ;
	// retention: 2.5 periods = five half periods
	localparam int RETAIN_HALVES  = 5;
	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		SM_OFF, SM_HIB, SM_DOZE, SM_RSV3, SM_CYC, SM_CYCPIN, SM_LEGCO, SM_RSV7
	} rfsc_mode_e;
	typedef enum logic [2:0] {ST_AWAKE, ST_DRAIN, ST_SLEEP, ST_WAKING, ST_POLL} rfsc_state_e;
	typedef struct packed {
		logic        valid;
		logic [63:0] dest;
		logic [31:0] age;
	} rfsc_msg_s;
endpackage

// ===== tb/rfsc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------
// host controller: sleep pin and cts
// ------------------------------------
module rfsc_host_model #(
	parameter int BYTE_CYC = 4 // one byte time in clocks
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// bench command and module pins
	input  wire logic wantSleep,
	input  wire logic ctsN,
	output logic      sleepRequest,
	output logic      hostReady
);
	int lowCnt; // clocks since cts fell
	// pin follows the command one edge later, like a port register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) sleepRequest <= 1'b0;
		else sleepRequest <= wantSleep;
	end
	// sending early would lose bytes before the input buffer is up
	always_ff @(posedge clk or posedge rst) begin
		if (rst) lowCnt <= 0;
		else if (ctsN) lowCnt <= 0;
		else if (lowCnt < 2 * BYTE_CYC) lowCnt <= lowCnt + 1;
	end
	assign hostReady = lowCnt == 2 * BYTE_CYC;
endmodule
`default_nettype wire

// ===== tb/rfsc_sleep_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------
// sleep controller checker
// ------------------------------------
module rfsc_sleep_ctrl_monitor
	import rfsc_pkg::*;
#(
	parameter int HIB_CYCLES  = 20,
	parameter int DOZE_CYCLES = 8
) (
	// clock, reset and register writes
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	// pins and core hooks
	input wire logic        sleepRequest,
	input wire logic        ctsN,
	input wire logic        hostActivity,
	input wire logic        radioActivity,
	input wire logic        coreBusy,
	input wire logic        sleeping,
	input wire logic        pollReq,
	input wire logic        msgSend,
	input wire logic        msgDropped
);
	// slack covers the sync flops and state hops
	localparam int HIB_MAX  = HIB_CYCLES + 8;
	localparam int DOZE_MAX = DOZE_CYCLES + 8;
	logic [2:0] modeR; // mode as last written
	wire pinMode = modeR == 3'h1 || modeR == 3'h2;
	wire offMode = modeR == 3'h0 || modeR == 3'h3 || modeR == 3'h6 || modeR == 3'h7;
	// only same-edge writes are mirrored; split writes would be missed
	always_ff @(posedge clk or posedge rst) begin
		if (rst) modeR <= 3'h0;
		else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == ADDR_CTRL)
			modeR <= s_axi_wdata[2:0];
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// request held with the core quiet long enough to drain
	sequence quietRequest;
		(pinMode && sleepRequest && !coreBusy) [*8];
	endsequence
	// pin released while asleep
	sequence pinRelease;
		sleeping && $fell(sleepRequest);
	endsequence
	AST_ENTER: assert property (quietRequest |-> sleeping) else $error("pin sleep not entered");
	AST_BUSY: assert property (pinMode && coreBusy && !sleeping |=> !sleeping) else $error("slept while busy");
	AST_DEAF: assert property (pinMode && sleeping && sleepRequest && (hostActivity || radioActivity)
		|=> sleeping) else $error("woken by activity");
	AST_CTS: assert property (sleeping |-> ctsN) else $error("cts low while asleep");
	AST_HIB: assert property (((modeR == 3'h1) and pinRelease) |-> ##[1:HIB_MAX] !ctsN) else $error("slow wake");
	AST_DOZE: assert property (((modeR == 3'h2) and pinRelease) |-> ##[1:DOZE_MAX] !ctsN) else $error("slow doze");
	AST_EDGE: assert property (((modeR == 3'h5) and pinRelease) |-> ##[1:HIB_MAX] !ctsN) else $error("no edge wake");
	AST_OFF: assert property (offMode && !sleeping |=> !sleeping) else $error("slept when off");
	AST_POLL: assert property (pollReq |=> !pollReq) else $error("poll not a pulse");
	AST_MSG: assert property (msgSend || msgDropped |=> !(msgSend || msgDropped)) else $error("message twice");
endmodule
bind rfsc_sleep_ctrl rfsc_sleep_ctrl_monitor #(
	.HIB_CYCLES (HIB_CYCLES),
	.DOZE_CYCLES(DOZE_CYCLES)
) rfsc_sleep_ctrl_monitor_i (.*);
`default_nettype wire

// ===== tb/rf_module_sleep_control_test.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------
// sleep controller testbench
// ------------------------------------
module rf_module_sleep_control_test import rfsc_pkg::*;;
	localparam int TICK = 10, HIB = 20, DOZE = 8; // shortened counts
	localparam int OFFM[4] = '{0, 3, 6, 7}; // modes that never sleep
	logic        clk, rst, wantSleep, hostReady, actEn, sleepRequest, ctsN;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, pollReceived, queuedDataRx;
	logic        hostActivity, radioActivity, coreBusy, sleeping, pollReq, msgSend, msgDropped;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, a, d;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic [63:0] pollSource, msgDest;
	int          seed, n, m, n_fail, check_count;
	rfsc_sleep_ctrl #(.TICK_CYCLES(TICK), .HIB_CYCLES(HIB), .DOZE_CYCLES(DOZE)) rfsc_sleep_ctrl_i (.*);
	rfsc_host_model rfsc_host_model_i (.*);
	// expected wake time of a pin mode
	function automatic int wakeCyc(input int md);
		return md == 1 ? HIB : DOZE;
	endfunction
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// bounded wait: 0 asleep, 1 ready, 2 poll, 3 send, 4 drop
	task automatic waitEv(input int sel, input int lim);
		for (n = 0; n < lim; n++) begin
			@(posedge clk);
			if (sel == 0 && sleeping || sel == 1 && !ctsN || sel == 2 && pollReq
				|| sel == 3 && msgSend || sel == 4 && msgDropped) return;
		end
		n_fail++;
		final_report;
	endtask
	// single write, address and data offered together
	task automatic axw(input logic [7:0] adr, input logic [31:0] dat);
		@(posedge clk);
		{s_axi_awaddr, s_axi_wdata} <= {adr, dat};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		for (n = 0; n < 50 && !s_axi_bvalid; n++) begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n == 50) waitEv(0, 0);
	endtask
	task automatic axr(input logic [7:0] adr);
		@(posedge clk);
		s_axi_araddr <= adr;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		for (n = 0; n < 50 && !s_axi_rvalid; n++) begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end
		{r, d} = {s_axi_rresp, s_axi_rdata};
		s_axi_rready <= 1'b0;
		if (n == 50) waitEv(0, 0);
	endtask
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// random serial, radio and core traffic
	always @(posedge clk) begin
		radioActivity <= actEn && $random(seed) % 4 == 0;
		hostActivity <= actEn && hostReady && $random(seed) % 4 == 0;
		coreBusy <= actEn && $random(seed) % 8 == 0;
	end
	initial begin
		{seed, n_fail, check_count} = {32'd71, 64'd0};
		{rst, actEn, wantSleep, pollReceived, queuedDataRx} = 5'h18;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, pollSource} = {48'h0, 4'hF, 64'h0};
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		axr(ADDR_CTRL);
		chk(d, 32'h0);
		axr(ADDR_PERIOD);
		chk(d, PERIOD_RST);
		axr(ADDR_IDLE);
		chk(d, IDLE_RST);
		axr(8'h1C);
		chk({r, d}, {RESP_SLVERR, 32'h0});
		// off, reserved and legacy modes ignore the request
		foreach (OFFM[i]) begin
			axw(ADDR_CTRL, 32'(OFFM[i]));
			wantSleep <= 1'b1;
			repeat (40) @(posedge clk);
			chk({sleeping, ctsN}, 2'h0);
		end
		wantSleep <= 1'b0;
		// coordinator: deliver on poll, then let one expire
		axw(ADDR_PERIOD, 32'h2);
		chk(r, RESP_OKAY);
		axw(ADDR_CTRL, 32'h8);
		axr(ADDR_STATUS);
		chk(d[4], 1'b1);
		a = $random(seed);
		axw(ADDR_MSGADDR, a);
		{pollSource, pollReceived} <= {32'h0, a, 1'b1};
		@(posedge clk);
		pollReceived <= 1'b0;
		waitEv(3, 20);
		chk(msgDest, {32'h0, a});
		axw(ADDR_MSGADDR, ~a);
		waitEv(4, 200);
		chk(n >= 4 * TICK && n <= 7 * TICK, 1'b1);
		// pin modes under radio noise
		for (m = 1; m <= 2; m++) begin
			axw(ADDR_CTRL, 32'(m));
			wantSleep <= 1'b1;
			waitEv(0, 200);
			repeat (10) @(posedge clk);
			chk({sleeping, ctsN}, 2'h3);
			wantSleep <= 1'b0;
			waitEv(1, 200);
			chk(n >= wakeCyc(m) && n <= wakeCyc(m) + 10, 1'b1);
		end
		// cyclic remote with an empty coordinator
		actEn <= 1'b0;
		axw(ADDR_IDLE, 32'h3);
		axw(ADDR_CTRL, 32'h4);
		waitEv(0, 200);
		repeat (2) begin
			waitEv(2, 300);
			chk(ctsN, 1'b0);
			chk(n >= TICK, 1'b1);
		end
		// data two ticks into the poll window: an empty poll would sleep by the
		// third tick, so still being awake well after it proves the timer restart
		repeat (19) @(posedge clk);
		queuedDataRx <= 1'b1;
		@(posedge clk);
		queuedDataRx <= 1'b0;
		repeat (15) @(posedge clk);
		chk({sleeping, ctsN}, 2'h0);
		waitEv(0, 100);
		// pin edge wake long before the period ends
		axw(ADDR_PERIOD, 32'h32);
		axw(ADDR_CTRL, 32'h5);
		wantSleep <= 1'b1;
		waitEv(1, 800);
		waitEv(0, 800);
		wantSleep <= 1'b0;
		waitEv(1, 60);
		chk(sleeping, 1'b0);
		wantSleep <= 1'b1;
		waitEv(0, 100);
		chk(n >= TICK, 1'b1);
		final_report;
	end
endmodule
`default_nettype wire
